// ### inc/xie_regs.svh
// Register offsets, bit positions and reset values of the extended
// interrupt enable block.
// Assumes byte-wide special-function registers on an 8-bit address.
`ifndef XIE_REGS_SVH
`define XIE_REGS_SVH

`define XIE_ADDR_W 8
`define XIE_DATA_W 8

`define XIE_OFF_FIRST_MASK 8'he6
`define XIE_OFF_SECOND_MASK 8'he7
`define XIE_OFF_STAT_FIRST 8'he8
`define XIE_OFF_STAT_SECOND 8'he9
`define XIE_OFF_CLR_FIRST 8'hea
`define XIE_OFF_CLR_SECOND 8'heb
`define XIE_OFF_EN_FIRST 8'hec
`define XIE_OFF_EN_SECOND 8'hed
`define XIE_OFF_RAW_FIRST 8'hee
`define XIE_OFF_RAW_SECOND 8'hef

`define XIE_RST_MASK 8'h00
`define XIE_RST_STAT 8'h00
`define XIE_RST_EN 8'h00
`define XIE_UNMAPPED_RD 8'h00

`define XIE_BIT_CMP1_RISE 7
`define XIE_BIT_CMP1_FALL 6
`define XIE_BIT_CMP0_RISE 5
`define XIE_BIT_CMP0_FALL 4
`define XIE_BIT_COUNTER_ARRAY 3
`define XIE_BIT_ADC_WINDOW 2
`define XIE_BIT_SYSMGMT_BUS 1
`define XIE_BIT_SERIAL_PERIPH 0

`define XIE_BIT_OSC_VALID 7
`define XIE_BIT_SECOND_UART 6
`define XIE_BIT_EXT_PIN_SEVEN 5
`define XIE_BIT_EXT_PIN_SIX 4
`define XIE_BIT_FAST_ADC_DONE 3
`define XIE_BIT_TIMER_FOUR 2
`define XIE_BIT_MAIN_ADC_DONE 1
`define XIE_BIT_TIMER_THREE 0

`endif

// ### inc/xie_pkg.sv
// Types shared by the extended interrupt enable block.
// Assumes xie_regs.svh is on the include path.
`include "xie_regs.svh"

package xie_pkg;

  typedef logic [`XIE_ADDR_W-1:0] xie_addr_t;
  typedef logic [`XIE_DATA_W-1:0] xie_byte_t;

  // Sources gated by the first mask register, msb first.
  typedef struct packed {
    logic cmp1_rise;
    logic cmp1_fall;
    logic cmp0_rise;
    logic cmp0_fall;
    logic counter_array;
    logic adc_window;
    logic sysmgmt_bus;
    logic serial_periph;
  } xie_first_src_t;

  // Sources gated by the second mask register, msb first.
  typedef struct packed {
    logic oscillator_valid_flag;
    logic second_uart;
    logic ext_pin_seven;
    logic ext_pin_six;
    logic fast_adc_done;
    logic timer_four;
    logic main_adc_done;
    logic timer_three_overflow_flag;
  } xie_second_src_t;

  typedef struct packed {
    xie_addr_t addr;
    xie_byte_t wdata;
    logic wr;
    logic rd;
  } xie_bus_t;

endpackage

// ### src/xie_mask_gate.sv
// Per-bit gate of one byte of interrupt requests by its enable bits.
// Assumes requests and enables come from logic on the same clock.
`timescale 1ns/10ps

module xie_mask_gate (
  input wire logic [7:0] req_i, // raw source requests
  input wire logic [7:0] mask_i, // enable bits, one passes
  output logic [7:0] pass_o // requests let through
);

  // ==========================================================
  // Gating.
  // ==========================================================
  // Only the path to the core is gated; the source flag is untouched.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign pass_o[g] = req_i[g] & mask_i[g];
    end
  endgenerate

endmodule // xie_mask_gate

// ### src/xie_event_bank.sv
// Sticky event bits: a rising edge of a passed request sets a bit,
// a one-cycle clear pulse clears it, and a set in the same cycle wins.
// Assumes inputs come from logic on clk_sys_i.
`timescale 1ns/10ps
`include "xie_regs.svh"

module xie_event_bank (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic [7:0] req_i, // passed requests
  input wire logic [7:0] clr_i, // clear pulse, one per bit
  output logic [7:0] stat_o // sticky status
);

  logic [7:0] req_prev;
  logic [7:0] next_stat;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      req_prev <= 8'h00;
    end else begin
      req_prev <= req_i;
    end
  end

  // ==========================================================
  // Set wins over clear.
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign next_stat[g] = (req_i[g] & ~req_prev[g]) |
                            (stat_o[g] & ~clr_i[g]);
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      stat_o <= `XIE_RST_STAT;
    end else begin
      stat_o <= next_stat;
    end
  end

endmodule // xie_event_bank

// ### src/xie_top.sv
// Extended interrupt enable: two mask registers that pass or block each
// extended interrupt source on its way to the core's interrupt logic,
// plus sticky event status with its own enable and interrupt line.
// Assumes all sources and the register port run on clk_sys_i (10 MHz).
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "xie_regs.svh"

// What this block does
// - First mask bits 7..4 gate comparator edges.
// - First mask bit 3 gates counter array.
// - Second mask bit 5 gates pin seven.
// - Second mask bit 4 gates pin six.
// - Second mask bit 0 gates timer three overflow.
// - Second mask bit 7 gates oscillator valid.
module xie_top (
  input wire logic clk_sys_i, // system clock, 10 MHz
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic [7:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  input wire xie_pkg::xie_first_src_t first_src_i, // raw requests, set 1
  input wire xie_pkg::xie_second_src_t second_src_i, // raw requests, set 2
  output xie_pkg::xie_first_src_t first_req_o, // gated requests, set 1
  output xie_pkg::xie_second_src_t second_req_o, // gated requests, set 2
  output logic [7:0] first_mask_o, // first mask register
  output logic [7:0] second_mask_o, // second mask register
  output logic irq_o // level interrupt of sticky events
);

  // ==========================================================
  // Address decode.
  // ==========================================================
  // The same compare is used for writes, reads and clears.
  function automatic logic xie_hit(
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    xie_hit = (addr == offset);
  endfunction

  xie_pkg::xie_bus_t bus;

  assign bus.addr = addr_i;
  assign bus.wdata = wdata_i;
  assign bus.wr = wr_i;
  assign bus.rd = rd_i;

  logic wr_first_mask;
  logic wr_second_mask;
  logic wr_clr_first;
  logic wr_clr_second;
  logic wr_en_first;
  logic wr_en_second;

  assign wr_first_mask = bus.wr & xie_hit(bus.addr, `XIE_OFF_FIRST_MASK);
  assign wr_second_mask = bus.wr &
                          xie_hit(bus.addr, `XIE_OFF_SECOND_MASK);
  assign wr_clr_first = bus.wr & xie_hit(bus.addr, `XIE_OFF_CLR_FIRST);
  assign wr_clr_second = bus.wr & xie_hit(bus.addr, `XIE_OFF_CLR_SECOND);
  assign wr_en_first = bus.wr & xie_hit(bus.addr, `XIE_OFF_EN_FIRST);
  assign wr_en_second = bus.wr & xie_hit(bus.addr, `XIE_OFF_EN_SECOND);

  // ==========================================================
  // First mask register.
  // ==========================================================
  logic [7:0] first_extended_irq_mask;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      first_extended_irq_mask <= `XIE_RST_MASK;
    end else if (wr_first_mask) begin
      first_extended_irq_mask <= bus.wdata;
    end
  end

  // Named views of the first mask.
  logic cmp1_rise_irq_on;
  logic cmp1_fall_irq_on;
  logic cmp0_rise_irq_on;
  logic cmp0_fall_irq_on;
  logic counter_array_irq_on;
  logic adc_window_irq_on;
  logic sysmgmt_bus_irq_on;
  logic serial_periph_irq_on;

  assign cmp1_rise_irq_on =
    first_extended_irq_mask[`XIE_BIT_CMP1_RISE];
  assign cmp1_fall_irq_on =
    first_extended_irq_mask[`XIE_BIT_CMP1_FALL];
  assign cmp0_rise_irq_on =
    first_extended_irq_mask[`XIE_BIT_CMP0_RISE];
  assign cmp0_fall_irq_on =
    first_extended_irq_mask[`XIE_BIT_CMP0_FALL];
  assign counter_array_irq_on =
    first_extended_irq_mask[`XIE_BIT_COUNTER_ARRAY];
  assign adc_window_irq_on =
    first_extended_irq_mask[`XIE_BIT_ADC_WINDOW];
  assign sysmgmt_bus_irq_on =
    first_extended_irq_mask[`XIE_BIT_SYSMGMT_BUS];
  assign serial_periph_irq_on =
    first_extended_irq_mask[`XIE_BIT_SERIAL_PERIPH];

  // ==========================================================
  // Second mask register.
  // ==========================================================
  logic [7:0] second_extended_irq_mask;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      second_extended_irq_mask <= `XIE_RST_MASK;
    end else if (wr_second_mask) begin
      second_extended_irq_mask <= bus.wdata;
    end
  end

  // Named views of the second mask.
  logic osc_valid_irq_on;
  logic second_uart_irq_on;
  logic ext_pin_seven_irq_on;
  logic ext_pin_six_irq_on;
  logic fast_adc_done_irq_on;
  logic timer_four_irq_on;
  logic main_adc_done_irq_on;
  logic timer_three_irq_on;

  assign osc_valid_irq_on =
    second_extended_irq_mask[`XIE_BIT_OSC_VALID];
  assign second_uart_irq_on =
    second_extended_irq_mask[`XIE_BIT_SECOND_UART];
  assign ext_pin_seven_irq_on =
    second_extended_irq_mask[`XIE_BIT_EXT_PIN_SEVEN];
  assign ext_pin_six_irq_on =
    second_extended_irq_mask[`XIE_BIT_EXT_PIN_SIX];
  assign fast_adc_done_irq_on =
    second_extended_irq_mask[`XIE_BIT_FAST_ADC_DONE];
  assign timer_four_irq_on =
    second_extended_irq_mask[`XIE_BIT_TIMER_FOUR];
  assign main_adc_done_irq_on =
    second_extended_irq_mask[`XIE_BIT_MAIN_ADC_DONE];
  assign timer_three_irq_on =
    second_extended_irq_mask[`XIE_BIT_TIMER_THREE];

  // ==========================================================
  // Assembly of the enable words in bit order.
  // ==========================================================
  // The mask words are rebuilt from the named views so that each
  // source is tied to its documented bit in one visible place.
  logic [7:0] first_gate;
  logic [7:0] second_gate;

  always_comb begin
    first_gate = 8'h00;
    first_gate[`XIE_BIT_CMP1_RISE] = cmp1_rise_irq_on;
    first_gate[`XIE_BIT_CMP1_FALL] = cmp1_fall_irq_on;
    first_gate[`XIE_BIT_CMP0_RISE] = cmp0_rise_irq_on;
    first_gate[`XIE_BIT_CMP0_FALL] = cmp0_fall_irq_on;
    first_gate[`XIE_BIT_COUNTER_ARRAY] = counter_array_irq_on;
    first_gate[`XIE_BIT_ADC_WINDOW] = adc_window_irq_on;
    first_gate[`XIE_BIT_SYSMGMT_BUS] = sysmgmt_bus_irq_on;
    first_gate[`XIE_BIT_SERIAL_PERIPH] = serial_periph_irq_on;
  end

  always_comb begin
    second_gate = 8'h00;
    second_gate[`XIE_BIT_OSC_VALID] = osc_valid_irq_on;
    second_gate[`XIE_BIT_SECOND_UART] = second_uart_irq_on;
    second_gate[`XIE_BIT_EXT_PIN_SEVEN] = ext_pin_seven_irq_on;
    second_gate[`XIE_BIT_EXT_PIN_SIX] = ext_pin_six_irq_on;
    second_gate[`XIE_BIT_FAST_ADC_DONE] = fast_adc_done_irq_on;
    second_gate[`XIE_BIT_TIMER_FOUR] = timer_four_irq_on;
    second_gate[`XIE_BIT_MAIN_ADC_DONE] = main_adc_done_irq_on;
    second_gate[`XIE_BIT_TIMER_THREE] = timer_three_irq_on;
  end

  // ==========================================================
  // Request gating.
  // ==========================================================
  // The gate is combinational so a request reaches the core in the
  // same cycle as its flag; adding a stage would delay every vector.
  logic [7:0] first_raw;
  logic [7:0] second_raw;
  logic [7:0] first_pass;
  logic [7:0] second_pass;

  // Raw words are built field by field from the source structs, so a
  // reordering of a struct cannot silently move a source onto another
  // mask bit. The raw words also feed the read-back views, which show
  // the flags before any mask.
  always_comb begin
    first_raw = 8'h00;
    first_raw[`XIE_BIT_CMP1_RISE] = first_src_i.cmp1_rise;
    first_raw[`XIE_BIT_CMP1_FALL] = first_src_i.cmp1_fall;
    first_raw[`XIE_BIT_CMP0_RISE] = first_src_i.cmp0_rise;
    first_raw[`XIE_BIT_CMP0_FALL] = first_src_i.cmp0_fall;
    first_raw[`XIE_BIT_COUNTER_ARRAY] = first_src_i.counter_array;
    first_raw[`XIE_BIT_ADC_WINDOW] = first_src_i.adc_window;
    first_raw[`XIE_BIT_SYSMGMT_BUS] = first_src_i.sysmgmt_bus;
    first_raw[`XIE_BIT_SERIAL_PERIPH] = first_src_i.serial_periph;
  end

  always_comb begin
    second_raw = 8'h00;
    second_raw[`XIE_BIT_OSC_VALID] = second_src_i.oscillator_valid_flag;
    second_raw[`XIE_BIT_SECOND_UART] = second_src_i.second_uart;
    second_raw[`XIE_BIT_EXT_PIN_SEVEN] = second_src_i.ext_pin_seven;
    second_raw[`XIE_BIT_EXT_PIN_SIX] = second_src_i.ext_pin_six;
    second_raw[`XIE_BIT_FAST_ADC_DONE] = second_src_i.fast_adc_done;
    second_raw[`XIE_BIT_TIMER_FOUR] = second_src_i.timer_four;
    second_raw[`XIE_BIT_MAIN_ADC_DONE] = second_src_i.main_adc_done;
    second_raw[`XIE_BIT_TIMER_THREE] = second_src_i.timer_three_overflow_flag;
  end

  xie_mask_gate u_first_gate (
    .req_i (first_raw),
    .mask_i (first_gate),
    .pass_o (first_pass)
  );

  xie_mask_gate u_second_gate (
    .req_i (second_raw),
    .mask_i (second_gate),
    .pass_o (second_pass)
  );

  assign first_req_o = first_pass;
  assign second_req_o = second_pass;
  assign first_mask_o = first_extended_irq_mask;
  assign second_mask_o = second_extended_irq_mask;

  // ==========================================================
  // Sticky event status.
  // ==========================================================
  // An event is the rising edge of a request after the mask, so a
  // masked source leaves no trace here.
  logic [7:0] clr_first;
  logic [7:0] clr_second;
  logic [7:0] stat_first;
  logic [7:0] stat_second;

  assign clr_first = wr_clr_first ? bus.wdata : 8'h00;
  assign clr_second = wr_clr_second ? bus.wdata : 8'h00;

  xie_event_bank u_first_events (
    .clk_sys_i (clk_sys_i),
    .rst_b_i (rst_b_i),
    .req_i (first_pass),
    .clr_i (clr_first),
    .stat_o (stat_first)
  );

  xie_event_bank u_second_events (
    .clk_sys_i (clk_sys_i),
    .rst_b_i (rst_b_i),
    .req_i (second_pass),
    .clr_i (clr_second),
    .stat_o (stat_second)
  );

  // ==========================================================
  // Event enables and interrupt line.
  // ==========================================================
  // Enables only select which sticky bits drive irq_o.
  logic [7:0] evt_en_first;
  logic [7:0] evt_en_second;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      evt_en_first <= `XIE_RST_EN;
    end else if (wr_en_first) begin
      evt_en_first <= bus.wdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      evt_en_second <= `XIE_RST_EN;
    end else if (wr_en_second) begin
      evt_en_second <= bus.wdata;
    end
  end

  // Level output; it drops in the cycle after the last enabled bit
  // is cleared or disabled.
  assign irq_o = |(stat_first & evt_en_first) |
                 |(stat_second & evt_en_second);

  // ==========================================================
  // Read path.
  // ==========================================================
  // Clear registers are write-only and read as zero, as do unmapped
  // addresses.  Raw views show the unmasked source flags.
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = `XIE_UNMAPPED_RD;
    case (1'b1)
      xie_hit(bus.addr, `XIE_OFF_FIRST_MASK): begin
        next_rdata = first_extended_irq_mask;
      end
      xie_hit(bus.addr, `XIE_OFF_SECOND_MASK): begin
        next_rdata = second_extended_irq_mask;
      end
      xie_hit(bus.addr, `XIE_OFF_STAT_FIRST): begin
        next_rdata = stat_first;
      end
      xie_hit(bus.addr, `XIE_OFF_STAT_SECOND): begin
        next_rdata = stat_second;
      end
      xie_hit(bus.addr, `XIE_OFF_EN_FIRST): begin
        next_rdata = evt_en_first;
      end
      xie_hit(bus.addr, `XIE_OFF_EN_SECOND): begin
        next_rdata = evt_en_second;
      end
      xie_hit(bus.addr, `XIE_OFF_RAW_FIRST): begin
        next_rdata = first_raw;
      end
      xie_hit(bus.addr, `XIE_OFF_RAW_SECOND): begin
        next_rdata = second_raw;
      end
      default: begin
        next_rdata = `XIE_UNMAPPED_RD;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  // Driving zero when idle lets several slaves share an OR-ed bus.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (bus.rd) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // xie_top

// ### test/xie_top_asserts.sv
// Concurrent checks on the ports of the extended interrupt enable top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`include "xie_regs.svh"

module xie_top_asserts (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic [7:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] rdata_o, // read data
  input wire xie_pkg::xie_first_src_t first_src_i, // raw set 1
  input wire xie_pkg::xie_second_src_t second_src_i, // raw set 2
  input wire xie_pkg::xie_first_src_t first_req_o, // gated set 1
  input wire xie_pkg::xie_second_src_t second_req_o, // gated set 2
  input wire logic [7:0] first_mask_o, // first mask
  input wire logic [7:0] second_mask_o, // second mask
  input wire logic irq_o // interrupt line
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  cmp_gate_a: assert property (
    first_req_o[7:4] == (first_src_i[7:4] & first_mask_o[7:4]))
    else $error("comparator gate wrong");
  ctr_gate_a: assert property (
    first_req_o[3] == (first_src_i[3] && first_mask_o[3]))
    else $error("counter array gate wrong");
  pin_seven_a: assert property (
    second_req_o[5] == (second_src_i[5] && second_mask_o[5]))
    else $error("pin seven gate wrong");
  pin_six_a: assert property (
    second_req_o[4] == (second_src_i[4] && second_mask_o[4]))
    else $error("pin six gate wrong");
  timer_three_a: assert property (
    second_req_o[0] == (second_src_i[0] && second_mask_o[0]))
    else $error("timer three gate wrong");
  osc_valid_a: assert property (
    second_req_o[7] == (second_src_i[7] && second_mask_o[7]))
    else $error("oscillator valid gate wrong");
  first_write_a: assert property (
    wr_i && addr_i == `XIE_OFF_FIRST_MASK |=>
      first_mask_o == $past(wdata_i))
    else $error("first mask write lost");
  second_write_a: assert property (
    wr_i && addr_i == `XIE_OFF_SECOND_MASK |=>
      second_mask_o == $past(wdata_i))
    else $error("second mask write lost");
  mask_hold_a: assert property (
    !(wr_i && addr_i == `XIE_OFF_FIRST_MASK) |=> $stable(first_mask_o))
    else $error("first mask changed unasked");
  raw_view_a: assert property (
    rd_i && addr_i == `XIE_OFF_RAW_FIRST |=>
      rdata_o == $past(first_src_i))
    else $error("raw flag view wrong");
endmodule // xie_top_asserts

bind xie_top xie_top_asserts u_chk (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .first_src_i(first_src_i),
  .second_src_i(second_src_i), .first_req_o(first_req_o),
  .second_req_o(second_req_o), .first_mask_o(first_mask_o),
  .second_mask_o(second_mask_o), .irq_o(irq_o));

// ### test/xie_flag_model.sv
// Peripheral interrupt flags that feed the block's raw request inputs.
// Assumes set and clear pulses from the bench on clk_sys_i.
`timescale 1ns/10ps

module xie_flag_model (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic [15:0] set_i, // set pulses, [15:8] second bank
  input wire logic [15:0] clr_i, // clear pulses, same layout
  output xie_pkg::xie_first_src_t first_src_o, // flags, first bank
  output xie_pkg::xie_second_src_t second_src_o // flags, second bank
);
  logic [15:0] flags;

  // Flags never look at the masks, so masking cannot disturb them.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      flags <= 16'h0000;
    end else begin
      flags <= (flags & ~clr_i) | set_i;
    end
  end

  assign first_src_o = flags[7:0];
  assign second_src_o = flags[15:8];
endmodule // xie_flag_model

// ### test/extended_interrupt_enable_tb_top.sv
// Self-checking bench for the extended interrupt enable block.
// Assumes the flag model on the source inputs and the bound checker.
`timescale 1ns/10ps
`include "xie_regs.svh"
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module extended_interrupt_enable_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o, first_mask_o, second_mask_o, d, e;
  logic irq_o;
  logic [15:0] flag_set = 16'h0000;
  logic [15:0] flag_clr = 16'h0000;
  xie_pkg::xie_first_src_t first_src, first_req;
  xie_pkg::xie_second_src_t second_src, second_req;
  int miscompares = 0;
  int n_checks = 0;

  xie_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .first_src_i(first_src), .second_src_i(second_src),
    .first_req_o(first_req), .second_req_o(second_req),
    .first_mask_o(first_mask_o), .second_mask_o(second_mask_o),
    .irq_o(irq_o));

  xie_flag_model u_flags (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .set_i(flag_set), .clr_i(flag_clr), .first_src_o(first_src),
    .second_src_o(second_src));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus and flag drivers
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic flags(input logic [15:0] s, input logic [15:0] c);
    @(posedge clk_sys_i);
    flag_set <= s;
    flag_clr <= c;
    @(posedge clk_sys_i);
    flag_set <= 16'h0000;
    flag_clr <= 16'h0000;
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    reg_rd(`XIE_OFF_FIRST_MASK, d);
    `CHK(d, 8'h00)
    reg_rd(`XIE_OFF_SECOND_MASK, d);
    `CHK(d, 8'h00)
    `CHK(irq_o, 1'b0)
  endtask

  // One mask bit at a time, with every source high.
  task automatic t_mask_walk;
    flags(16'hffff, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      reg_wr(`XIE_OFF_FIRST_MASK, 8'h01 << i);
      reg_wr(`XIE_OFF_SECOND_MASK, 8'h80 >> i);
      e = 8'h01 << i;
      `CHK(first_req, e)
      e = 8'h80 >> i;
      `CHK(second_req, e)
    end
    reg_wr(`XIE_OFF_FIRST_MASK, 8'h00);
    reg_wr(`XIE_OFF_SECOND_MASK, 8'h00);
    `CHK(first_req, 8'h00)
    `CHK(second_req, 8'h00)
    flags(16'h0000, 16'hffff);
    reg_wr(`XIE_OFF_CLR_FIRST, 8'hff);
    reg_wr(`XIE_OFF_CLR_SECOND, 8'hff);
  endtask

  task automatic t_rw_back;
    reg_wr(`XIE_OFF_FIRST_MASK, 8'ha5);
    reg_wr(`XIE_OFF_SECOND_MASK, 8'h21);
    reg_wr(8'hd0, 8'hff);
    reg_rd(`XIE_OFF_FIRST_MASK, d);
    `CHK(d, 8'ha5)
    `CHK(first_mask_o, 8'ha5)
    reg_rd(`XIE_OFF_SECOND_MASK, d);
    `CHK(d, 8'h21)
    `CHK(second_mask_o, 8'h21)
    @(posedge clk_sys_i);
    #1 `CHK(rdata_o, 8'h00)
    reg_rd(8'hd0, d);
    `CHK(d, 8'h00)
    flags(16'h3f00, 16'h0000);
    `CHK(second_req, 8'h21)
    flags(16'h0000, 16'hffff);
    reg_rd(`XIE_OFF_STAT_SECOND, d);
    `CHK(d, 8'h21)
    reg_wr(`XIE_OFF_EN_SECOND, 8'h01);
    `CHK(irq_o, 1'b1)
    reg_rd(`XIE_OFF_EN_SECOND, d);
    `CHK(d, 8'h01)
    reg_wr(`XIE_OFF_CLR_SECOND, 8'h21);
    `CHK(irq_o, 1'b0)
    reg_rd(`XIE_OFF_STAT_SECOND, d);
    `CHK(d, 8'h00)
    reg_wr(`XIE_OFF_EN_SECOND, 8'h00);
  endtask

  // A masked source keeps its flag and never reaches status.
  task automatic t_masked_flag;
    reg_wr(`XIE_OFF_FIRST_MASK, 8'h00);
    reg_wr(`XIE_OFF_SECOND_MASK, 8'h00);
    flags(16'h0108, 16'h0000);
    `CHK(first_req, 8'h00)
    `CHK(second_req, 8'h00)
    reg_rd(`XIE_OFF_RAW_FIRST, d);
    `CHK(d, 8'h08)
    reg_rd(`XIE_OFF_RAW_SECOND, d);
    `CHK(d, 8'h01)
    reg_rd(`XIE_OFF_STAT_FIRST, d);
    `CHK(d, 8'h00)
    flags(16'h0000, 16'hffff);
  endtask

  task automatic t_irq;
    int k;
    reg_wr(`XIE_OFF_EN_FIRST, 8'h08);
    reg_wr(`XIE_OFF_FIRST_MASK, 8'h08);
    flags(16'h0008, 16'h0000);
    for (k = 0; k < 4 && irq_o !== 1'b1; k++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (k == 4) begin
      miscompares++;
      give_verdict;
    end
    reg_rd(`XIE_OFF_STAT_FIRST, d);
    `CHK(d, 8'h08)
    flags(16'h0000, 16'h0008);
    reg_wr(`XIE_OFF_EN_FIRST, 8'h00);
    `CHK(irq_o, 1'b0)
    reg_wr(`XIE_OFF_EN_FIRST, 8'h08);
    `CHK(irq_o, 1'b1)
    reg_wr(`XIE_OFF_CLR_FIRST, 8'h08);
    `CHK(irq_o, 1'b0)
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset_values();
    t_mask_walk();
    t_rw_back();
    t_masked_flag();
    t_irq();
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    give_verdict;
  end
endmodule // extended_interrupt_enable_tb_top
